// File: core/serep_pkg.sv
// Purpose: Shared constants and types for the serial endpoint routing and
//          transmit flow control block.
// Assumes: Build-time choices are package constants or top parameters.
// Notes:   All timing is counted on ref_clk (200 MHz).
package serep_pkg;

  // ==========================================================================
  // Address match
  localparam int unsigned ADDR_W = 34;
  localparam int unsigned CFG_MASK_W = 10;
  localparam int unsigned CFG_MATCH_LSB = 24;
  localparam int unsigned CFG_MATCH_MSB = 33;
  localparam logic [9:0] CFG_MASK_RST = 10'h3FF;

  // ==========================================================================
  // Transaction type codes carried beside each packet (4 bits)
  localparam int unsigned TT_W = 4;
  localparam logic [3:0] TT_NREAD = 4'h2;
  localparam logic [3:0] TT_NWRITE = 4'h5;
  localparam logic [3:0] TT_NWRITE_R = 4'h4;
  localparam logic [3:0] TT_SWRITE = 4'h6;
  localparam logic [3:0] TT_DOORBELL = 4'hA;
  localparam logic [3:0] TT_MESSAGE = 4'hB;
  localparam logic [3:0] TT_MAINT = 4'h8;
  localparam logic [3:0] TT_RESPONSE = 4'hD;
  localparam logic [3:0] TT_PORT_WRITE = 4'h9;
  localparam logic [3:0] TT_USER_DEF = 4'hF;

  // ==========================================================================
  // Receive port selection
  typedef enum logic [2:0] {
    SEREP_DST_IO     = 3'b000,
    SEREP_DST_TARGET = 3'b001,
    SEREP_DST_INIT   = 3'b010,
    SEREP_DST_MAINT  = 3'b011,
    SEREP_DST_USER   = 3'b100,
    SEREP_DST_MSG    = 3'b101,
    SEREP_DST_DROP   = 3'b110
  } serep_dst_t;

  // Port and message styles
  localparam logic PORT_STYLE_CONDENSED = 1'b0;
  localparam logic PORT_STYLE_INIT_TGT = 1'b1;
  typedef enum logic [1:0] {
    SEREP_MSG_WITH_IO   = 2'b00,
    SEREP_MSG_SEPARATE  = 2'b01,
    SEREP_MSG_WITH_USER = 2'b10
  } serep_msg_style_t;

  // Packet format: 1 = header-lite, 0 = raw stream
  localparam logic FMT_RAW_STREAM = 1'b0;
  localparam logic FMT_HEADER_LITE = 1'b1;

  // ==========================================================================
  // Transmit flow control
  localparam int unsigned BUF_CNT_W = 6;
  localparam int unsigned PRIO_W = 2;
  localparam logic [5:0] LOWEST_PRIO_THR_RST = 6'h03;
  localparam logic [5:0] MEDIUM_PRIO_THR_RST = 6'h02;
  localparam logic [5:0] HIGH_PRIO_THR_RST = 6'h01;

  // Link request retry limit; 7 means never fatal
  localparam int unsigned LREQ_W = 3;
  localparam logic [2:0] LREQ_LIMIT_RST = 3'h0;
  localparam logic [2:0] LREQ_NEVER_FATAL = 3'h7;

  // Idle sequences and lane rate (Mbaud)
  localparam int unsigned RATE_MBAUD_W = 13;
  localparam logic [12:0] RATE_IDLE1_MAX_MBAUD = 13'h1388;
  localparam int unsigned IDLE2_LFSR_W = 16;
  localparam logic [15:0] IDLE2_LFSR_SEED = 16'hACE1;
  typedef enum logic [1:0] {
    SEREP_IDLE_TRAIN = 2'b00,
    SEREP_IDLE_ONE   = 2'b01,
    SEREP_IDLE_TWO   = 2'b10
  } serep_idle_t;

  typedef enum logic [1:0] {
    SEREP_LNK_OK    = 2'b00,
    SEREP_LNK_WAIT  = 2'b01,
    SEREP_LNK_FATAL = 2'b10
  } serep_lnk_t;

endpackage : serep_pkg

// File: core/serep_core.sv
// Purpose: Incoming routing, transmit ordering and priority gating, link
//          request retry limit and idle sequence choice of a serial endpoint.
// Assumes: One clock ref_clk at 200 MHz; synchronous active low rstn; all
//          inputs come from logic on the same clock.
// Notes:   Packets are described by header fields only; data paths are
//          outside. Software reaches a few registers over a plain port.
`timescale 1ns/1ps
`default_nettype none

module serep_core #(
  parameter logic PORT_STYLE = serep_pkg::PORT_STYLE_INIT_TGT,
  parameter logic USER_PORT_EN = 1'b1,
  parameter logic IO_FMT = serep_pkg::FMT_HEADER_LITE,
  parameter logic MSG_FMT = serep_pkg::FMT_HEADER_LITE,
  parameter serep_pkg::serep_msg_style_t MSG_STYLE = serep_pkg::SEREP_MSG_WITH_IO,
  parameter logic CFG_MATCH_EN = 1'b1,
  parameter logic [15:0] TT_ENABLED = 16'h2C74,
  parameter logic REORDER_EN = 1'b1,
  parameter logic RX_FC_ONLY = 1'b0,
  parameter logic [12:0] LANE_RATE_MBAUD = 13'h1388,
  parameter logic IDLE1_EN = 1'b1,
  parameter logic IDLE2_EN = 1'b1,
  parameter int unsigned TXQ_DEPTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Incoming packet header from the link
  input wire logic rx_valid,
  input wire logic [3:0] rx_ttype,
  input wire logic [33:0] rx_addr,
  input wire logic rx_is_response,
  input wire logic rx_is_local_resp,
  output logic rx_route_valid,
  output serep_pkg::serep_dst_t rx_route_dst,
  output logic rx_route_fmt,
  // Outgoing packet header from user ports
  input wire logic txq_in_valid,
  input wire logic [3:0] txq_in_ttype,
  input wire logic [1:0] txq_in_prio,
  input wire logic txq_in_is_response,
  output logic txq_in_ready,
  output logic tx_valid,
  output logic [1:0] tx_prio,
  output logic [3:0] tx_ttype,
  output logic tx_is_response,
  input wire logic tx_ready,
  // Partner buffer status and acknowledges
  input wire logic partner_tx_ctrl,
  input wire logic partner_status_valid,
  input wire logic [5:0] partner_free_bufs,
  input wire logic pkt_acked,
  // Link maintenance
  input wire logic link_req_sent,
  input wire logic link_resp_rcvd,
  output logic link_fatal,
  // Idle sequence
  input wire logic idle_train_done,
  input wire logic idle_train_pick2,
  input wire logic [2:0] link_width,
  input wire logic [3:0] lane_polarity,
  output logic idle1_sel,
  output logic idle2_sel,
  output logic short_ctrl_sym,
  output logic [22:0] idle2_info,
  output logic tx_fc_active
);

  // ==========================================================================
  // Register map (word index)
  localparam logic [3:0] REG_CFG_MASK = 4'h0;
  localparam logic [3:0] REG_LOWEST_THR = 4'h1;
  localparam logic [3:0] REG_MEDIUM_THR = 4'h2;
  localparam logic [3:0] REG_HIGH_THR = 4'h3;
  localparam logic [3:0] REG_LREQ_LIMIT = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;

  logic [9:0] cfg_mask, next_cfg_mask;
  logic [5:0] lowest_priority_threshold, next_lowest_priority_threshold;
  logic [5:0] medium_priority_threshold, next_medium_priority_threshold;
  logic [5:0] high_priority_threshold, next_high_priority_threshold;
  logic [2:0] lreq_limit, next_lreq_limit;
  logic [15:0] next_reg_rdata;
  logic [5:0] eff_free;
  logic [5:0] unacked;
  serep_pkg::serep_lnk_t lnk_state;
  logic [2:0] lreq_cnt;

  // Register writes and one-cycle-late reads
  always_comb begin
    next_cfg_mask = cfg_mask;
    next_lowest_priority_threshold = lowest_priority_threshold;
    next_medium_priority_threshold = medium_priority_threshold;
    next_high_priority_threshold = high_priority_threshold;
    next_lreq_limit = lreq_limit;
    next_reg_rdata = 16'h0000;
    if (reg_wr) begin
      case (reg_addr)
        REG_CFG_MASK: next_cfg_mask = reg_wdata[9:0];
        REG_LOWEST_THR: next_lowest_priority_threshold = reg_wdata[5:0];
        REG_MEDIUM_THR: next_medium_priority_threshold = reg_wdata[5:0];
        REG_HIGH_THR: next_high_priority_threshold = reg_wdata[5:0];
        REG_LREQ_LIMIT: next_lreq_limit = reg_wdata[2:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_CFG_MASK: next_reg_rdata = {6'h00, cfg_mask};
        REG_LOWEST_THR: next_reg_rdata = {10'h000, lowest_priority_threshold};
        REG_MEDIUM_THR: next_reg_rdata = {10'h000, medium_priority_threshold};
        REG_HIGH_THR: next_reg_rdata = {10'h000, high_priority_threshold};
        REG_LREQ_LIMIT: next_reg_rdata = {13'h0000, lreq_limit};
        REG_STATUS: next_reg_rdata = {eff_free, unacked, tx_fc_active, link_fatal,
                                      idle2_sel, idle1_sel};
        default: next_reg_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cfg_mask <= serep_pkg::CFG_MASK_RST;
      lowest_priority_threshold <= serep_pkg::LOWEST_PRIO_THR_RST;
      medium_priority_threshold <= serep_pkg::MEDIUM_PRIO_THR_RST;
      high_priority_threshold <= serep_pkg::HIGH_PRIO_THR_RST;
      lreq_limit <= serep_pkg::LREQ_LIMIT_RST;
      reg_rdata <= 16'h0000;
    end else begin
      cfg_mask <= next_cfg_mask;
      lowest_priority_threshold <= next_lowest_priority_threshold;
      medium_priority_threshold <= next_medium_priority_threshold;
      high_priority_threshold <= next_high_priority_threshold;
      lreq_limit <= next_lreq_limit;
      reg_rdata <= next_reg_rdata;
    end
  end

  // ==========================================================================
  // Receive routing
  logic tt_en, cfg_hit, is_user, is_msg, is_pw;
  serep_pkg::serep_dst_t next_dst;
  logic next_fmt, next_rvalid;

  always_comb begin
    tt_en = TT_ENABLED[rx_ttype] || rx_is_response;
    is_user = (rx_ttype == serep_pkg::TT_USER_DEF);
    is_msg = (rx_ttype == serep_pkg::TT_MESSAGE);
    is_pw = (rx_ttype == serep_pkg::TT_PORT_WRITE);
    cfg_hit = CFG_MATCH_EN && (IO_FMT == serep_pkg::FMT_HEADER_LITE) && tt_en
              && !rx_is_response && !is_user && !is_msg
              && (rx_addr[serep_pkg::CFG_MATCH_MSB:serep_pkg::CFG_MATCH_LSB]
                  == cfg_mask);
    next_rvalid = rx_valid;
    next_fmt = IO_FMT;
    if (is_pw) begin
      next_dst = serep_pkg::SEREP_DST_DROP;
    end else if (rx_ttype == serep_pkg::TT_MAINT || cfg_hit) begin
      next_dst = serep_pkg::SEREP_DST_MAINT;
    end else if (is_msg && MSG_STYLE == serep_pkg::SEREP_MSG_SEPARATE) begin
      next_dst = serep_pkg::SEREP_DST_MSG;
      next_fmt = MSG_FMT;
    end else if (is_user || (is_msg && MSG_STYLE == serep_pkg::SEREP_MSG_WITH_USER)) begin
      // Unqualified user traffic needing redirection is left to user logic
      next_dst = USER_PORT_EN ? serep_pkg::SEREP_DST_USER : serep_pkg::SEREP_DST_IO;
      next_fmt = USER_PORT_EN ? serep_pkg::FMT_RAW_STREAM : IO_FMT;
    end else if (PORT_STYLE == serep_pkg::PORT_STYLE_CONDENSED) begin
      next_dst = serep_pkg::SEREP_DST_IO;
    end else if (rx_is_response) begin
      next_dst = serep_pkg::SEREP_DST_INIT;
    end else begin
      next_dst = serep_pkg::SEREP_DST_TARGET;
    end
    // Header-lite needs a decoder for this type, else raw stream
    if (next_fmt == serep_pkg::FMT_HEADER_LITE && !tt_en && !is_msg) begin
      next_fmt = serep_pkg::FMT_RAW_STREAM;
    end
    if (next_dst == serep_pkg::SEREP_DST_DROP) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rx_route_valid <= 1'b0;
      rx_route_dst <= serep_pkg::SEREP_DST_IO;
      rx_route_fmt <= 1'b0;
    end else begin
      rx_route_valid <= next_rvalid;
      rx_route_dst <= next_dst;
      rx_route_fmt <= next_fmt;
    end
  end

  // ==========================================================================
  // Transmit queue: lowest-free slots tagged by arrival, picked by class then priority
  logic [TXQ_DEPTH-1:0] q_v, next_q_v;
  logic [1:0] q_prio [TXQ_DEPTH];
  logic [3:0] q_tt [TXQ_DEPTH];
  logic [TXQ_DEPTH-1:0] q_rsp;
  logic [31:0] q_seq [TXQ_DEPTH];
  logic [31:0] seq_cnt;
  logic [$clog2(TXQ_DEPTH)-1:0] wr_slot, pick;
  logic have_free, pick_ok;
  logic [3:0] prio_ok;
  logic accept, send;

  // Free slot and gated selection
  always_comb begin
    wr_slot = '0;
    have_free = 1'b0;
    for (int i = TXQ_DEPTH - 1; i >= 0; i--) begin
      if (!q_v[i]) begin
        wr_slot = i[$clog2(TXQ_DEPTH)-1:0];
        have_free = 1'b1;
      end
    end
    pick = '0;
    pick_ok = 1'b0;
    for (int i = 0; i < TXQ_DEPTH; i++) begin
      if (q_v[i] && (q_rsp[i] || prio_ok[q_prio[i]])) begin
        if (!pick_ok) begin
          pick = i[$clog2(TXQ_DEPTH)-1:0];
          pick_ok = 1'b1;
        end else if (q_rsp[i] != q_rsp[pick]) begin
          if (q_rsp[i]) pick = i[$clog2(TXQ_DEPTH)-1:0];
        end else if (REORDER_EN && !q_rsp[i] && q_prio[i] != q_prio[pick]) begin
          if (q_prio[i] > q_prio[pick]) pick = i[$clog2(TXQ_DEPTH)-1:0];
        end else if (q_seq[i] < q_seq[pick]) begin
          pick = i[$clog2(TXQ_DEPTH)-1:0];
        end
      end
    end
    // Without reordering, only the oldest request may leave
    if (!REORDER_EN && pick_ok && !q_rsp[pick]) begin
      for (int i = 0; i < TXQ_DEPTH; i++) begin
        if (q_v[i] && !q_rsp[i] && q_seq[i] < q_seq[pick]) pick_ok = 1'b0;
      end
    end
    txq_in_ready = have_free;
    accept = txq_in_valid && have_free && txq_in_ttype != serep_pkg::TT_PORT_WRITE;
    tx_valid = pick_ok;
    tx_prio = q_prio[pick];
    tx_ttype = q_tt[pick];
    tx_is_response = q_rsp[pick];
    send = pick_ok && tx_ready;
    next_q_v = q_v;
    if (send) next_q_v[pick] = 1'b0;
    if (txq_in_valid && have_free) next_q_v[wr_slot] = accept;
  end

  // Slot storage; port-write requests are never stored
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      q_v <= '0;
      seq_cnt <= 32'h00000000;
    end else begin
      q_v <= next_q_v;
      if (accept) begin
        q_prio[wr_slot] <= txq_in_prio;
        q_tt[wr_slot] <= txq_in_ttype;
        q_rsp[wr_slot] <= txq_in_is_response;
        q_seq[wr_slot] <= seq_cnt;
        seq_cnt <= seq_cnt + 32'h00000001;
      end
    end
  end

  // ==========================================================================
  // Partner credit and watermark gating
  logic fc_tx, next_fc_tx;
  logic [5:0] partner_bufs, next_partner_bufs, next_unacked;

  always_comb begin
    next_fc_tx = fc_tx;
    if (partner_status_valid && !partner_tx_ctrl) next_fc_tx = 1'b0;
    next_partner_bufs = partner_status_valid ? partner_free_bufs : partner_bufs;
    next_unacked = unacked + {5'h00, send} - {5'h00, pkt_acked && unacked != 6'h00};
    eff_free = (partner_bufs > unacked) ? partner_bufs - unacked : 6'h00;
    if (fc_tx) begin
      prio_ok[0] = eff_free >= lowest_priority_threshold;
      prio_ok[1] = eff_free >= medium_priority_threshold;
      prio_ok[2] = eff_free >= high_priority_threshold;
      prio_ok[3] = eff_free != 6'h00;
    end else begin
      prio_ok = 4'hF;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      fc_tx <= !RX_FC_ONLY;
      partner_bufs <= 6'h00;
      unacked <= 6'h00;
    end else begin
      fc_tx <= next_fc_tx;
      partner_bufs <= next_partner_bufs;
      unacked <= next_unacked;
    end
  end
  assign tx_fc_active = fc_tx;

  // ==========================================================================
  // Link request retry limit
  serep_pkg::serep_lnk_t next_lnk_state;
  logic [2:0] next_lreq_cnt;

  always_comb begin
    next_lnk_state = lnk_state;
    next_lreq_cnt = lreq_cnt;
    case (lnk_state)
      serep_pkg::SEREP_LNK_OK: begin
        if (link_req_sent) begin
          next_lreq_cnt = 3'h1;
          next_lnk_state = serep_pkg::SEREP_LNK_WAIT;
        end
      end
      serep_pkg::SEREP_LNK_WAIT: begin
        if (link_resp_rcvd) begin
          next_lreq_cnt = 3'h0;
          next_lnk_state = serep_pkg::SEREP_LNK_OK;
        end else if (link_req_sent && lreq_cnt != 3'h7) begin
          next_lreq_cnt = lreq_cnt + 3'h1;
        end
        if (!link_resp_rcvd && lreq_limit != serep_pkg::LREQ_NEVER_FATAL
            && next_lreq_cnt > lreq_limit) begin
          next_lnk_state = serep_pkg::SEREP_LNK_FATAL;
        end
      end
      serep_pkg::SEREP_LNK_FATAL: next_lnk_state = serep_pkg::SEREP_LNK_FATAL;
      default: next_lnk_state = serep_pkg::SEREP_LNK_OK;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      lnk_state <= serep_pkg::SEREP_LNK_OK;
      lreq_cnt <= 3'h0;
    end else begin
      lnk_state <= next_lnk_state;
      lreq_cnt <= next_lreq_cnt;
    end
  end
  assign link_fatal = (lnk_state == serep_pkg::SEREP_LNK_FATAL);

  // ==========================================================================
  // Idle sequence selection and second-idle content
  localparam logic RATE_LOW = (LANE_RATE_MBAUD <= serep_pkg::RATE_IDLE1_MAX_MBAUD);
  localparam logic USE1 = IDLE1_EN && RATE_LOW;
  localparam logic USE2 = IDLE2_EN || !USE1;
  serep_pkg::serep_idle_t idle_st, next_idle_st;
  logic [15:0] lfsr, next_lfsr;

  always_comb begin
    next_idle_st = idle_st;
    case (idle_st)
      serep_pkg::SEREP_IDLE_TRAIN: begin
        if (idle_train_done) begin
          next_idle_st = idle_train_pick2 ? serep_pkg::SEREP_IDLE_TWO
                                          : serep_pkg::SEREP_IDLE_ONE;
        end
      end
      serep_pkg::SEREP_IDLE_ONE: next_idle_st = serep_pkg::SEREP_IDLE_ONE;
      serep_pkg::SEREP_IDLE_TWO: next_idle_st = serep_pkg::SEREP_IDLE_TWO;
      default: next_idle_st = serep_pkg::SEREP_IDLE_TRAIN;
    endcase
    next_lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      idle_st <= (USE1 && USE2) ? serep_pkg::SEREP_IDLE_TRAIN
               : (USE1 ? serep_pkg::SEREP_IDLE_ONE : serep_pkg::SEREP_IDLE_TWO);
      lfsr <= serep_pkg::IDLE2_LFSR_SEED;
      idle2_info <= 23'h000000;
    end else begin
      idle_st <= next_idle_st;
      lfsr <= next_lfsr;
      idle2_info <= {link_width, lane_polarity, lfsr};
    end
  end

  // Short control symbols go with the first idle
  assign idle1_sel = (idle_st == serep_pkg::SEREP_IDLE_ONE);
  assign idle2_sel = (idle_st == serep_pkg::SEREP_IDLE_TWO);
  assign short_ctrl_sym = idle1_sel;

endmodule : serep_core

`default_nettype wire

// File: sim/serep_partner.sv
// Purpose: Remote endpoint model: buffer status, acks, link responses.
// Assumes: Same clock as the block.
// Notes: Stall, buffer level and answering are set by the bench.
`timescale 1ns/1ps
`default_nettype none
module serep_partner (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Bench controls
  input wire logic stall,
  input wire logic answer,
  input wire logic tx_ctrl,
  input wire logic [5:0] bufs,
  // Link side
  input wire logic tx_valid,
  input wire logic link_req_sent,
  output logic tx_ready,
  output logic partner_tx_ctrl,
  output logic partner_status_valid,
  output var logic [5:0] partner_free_bufs,
  output var logic pkt_acked,
  output var logic link_resp_rcvd
);
  // ==========
  // Status each cycle, ack one cycle after each transfer
  assign tx_ready = !stall;
  assign partner_tx_ctrl = tx_ctrl;
  assign partner_status_valid = rstn;
  always_ff @(posedge ref_clk) begin
    partner_free_bufs <= bufs;
    pkt_acked <= rstn && tx_valid && !stall;
    link_resp_rcvd <= rstn && answer && link_req_sent;
  end
endmodule : serep_partner
`default_nettype wire

// File: sim/serep_core_props.sv
// Purpose: Port assertions for serep_core.
// Assumes: One clock; synchronous active low reset.
// Notes: Bound to every serep_core instance.
`timescale 1ns/1ps
`default_nettype none
module serep_core_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register and receive side
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic rx_valid,
  input wire logic [3:0] rx_ttype,
  input wire logic rx_is_response,
  input wire logic rx_route_valid,
  input wire serep_pkg::serep_dst_t rx_route_dst,
  input wire logic rx_route_fmt,
  // Transmit and link side
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [3:0] tx_ttype,
  input wire logic [1:0] tx_prio,
  input wire logic partner_status_valid,
  input wire logic partner_tx_ctrl,
  input wire logic link_req_sent,
  input wire logic link_fatal,
  input wire logic idle1_sel,
  input wire logic short_ctrl_sym,
  input wire logic tx_fc_active
);
  // ==========
  // Clocking and sequences
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_rx_take;
    rx_valid && rx_ttype != serep_pkg::TT_PORT_WRITE;
  endsequence
  sequence s_tx_stall;
    tx_valid && !tx_ready;
  endsequence
  // ==========
  // Assertions
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside answer");
  chk_route_latency: assert property (s_rx_take |=> rx_route_valid)
    else $error("route missing one cycle after header");
  chk_pw_drop: assert property (rx_valid && !rx_ttype[1] && rx_ttype == 4'h9 |=> !rx_route_valid)
    else $error("port-write routed");
  chk_resp_nomatch: assert property (rx_valid && rx_is_response |=> rx_route_dst != serep_pkg::SEREP_DST_MAINT)
    else $error("response routed to maintenance");
  chk_user_raw: assert property (rx_route_valid && rx_route_dst == serep_pkg::SEREP_DST_USER |-> !rx_route_fmt)
    else $error("user port not raw stream");
  chk_tx_hold: assert property (s_tx_stall |=> tx_valid && $stable(tx_prio) && $stable(tx_ttype))
    else $error("stalled head changed");
  chk_tx_no_pw: assert property (tx_valid |-> tx_ttype != serep_pkg::TT_PORT_WRITE)
    else $error("port-write sent");
  chk_fatal_sticky: assert property (link_fatal |=> link_fatal)
    else $error("fatal state left without reset");
  chk_fatal_cause: assert property ($rose(link_fatal) |-> $past(link_req_sent) || $past(link_req_sent, 2))
    else $error("fatal without link request");
  chk_idle1_short: assert property (idle1_sel |-> short_ctrl_sym)
    else $error("first idle without short symbols");
  chk_fc_fallback: assert property (partner_status_valid && !partner_tx_ctrl |=> !tx_fc_active)
    else $error("no fallback to receiver control");
endmodule : serep_core_props
bind serep_core serep_core_props u_chk (.*);
`default_nettype wire

// File: sim/serep_core_test.sv
// Purpose: Self-checking bench for serep_core.
// Assumes: Default build parameters of the block.
// Notes: Partner model gives status, acks and link responses.
`timescale 1ns/1ps
`default_nettype none
module serep_core_test;
  logic ref_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rx_valid = 1'b0;
  logic rx_is_response = 1'b0, rx_is_local_resp = 1'b0, txq_in_valid = 1'b0;
  logic txq_in_is_response = 1'b0, link_req_sent = 1'b0, idle_train_done = 1'b0;
  logic idle_train_pick2 = 1'b1, stall = 1'b1, answer = 1'b1, tx_ctrl = 1'b1;
  logic [3:0] reg_addr = 4'h0, rx_ttype = 4'h0, txq_in_ttype = 4'h0, lane_polarity = 4'h5;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [33:0] rx_addr = 34'h0;
  logic [1:0] txq_in_prio = 2'h0, tx_prio;
  logic [2:0] link_width = 3'h4;
  logic [5:0] bufs = 6'h00, partner_free_bufs;
  logic [3:0] tx_ttype;
  logic [22:0] idle2_info;
  logic rx_route_valid, rx_route_fmt, txq_in_ready, tx_valid, tx_is_response, tx_ready;
  logic partner_tx_ctrl, partner_status_valid, pkt_acked, link_resp_rcvd, link_fatal;
  logic idle1_sel, idle2_sel, short_ctrl_sym, tx_fc_active;
  serep_pkg::serep_dst_t rx_route_dst;
  int err_total = 0, checks_done = 0;
  serep_core DUT (.*);
  serep_partner partner (.*);
  // ==========
  // Clock and shared tasks
  always #2.5 ref_clk = ~ref_clk;
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask : step
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic end_of_test();
    if (err_total == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic reg_io(logic [3:0] a, logic wr, logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    step();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // Read data stand only in the cycle right after the strobe
    if (!wr) chk("reg_rdata", reg_rdata, d);
    step();
  endtask : reg_io
  task automatic rx_chk(logic [3:0] tt, logic rsp, logic [9:0] hi, logic v, logic [2:0] d);
    rx_ttype <= tt;
    rx_is_response <= rsp;
    rx_addr <= {hi, 24'h000123};
    rx_valid <= 1'b1;
    step();
    rx_valid <= 1'b0;
    chk("route_valid", rx_route_valid, v);
    if (v) chk("route_dst", rx_route_dst, d);
    if (v && d != 3'h3) chk("route_fmt", rx_route_fmt, d != 3'h4);
    // Let an edge pass before the next header raises valid again
    step();
  endtask : rx_chk
  task automatic enq(logic [1:0] p, logic rsp);
    txq_in_ttype <= rsp ? serep_pkg::TT_RESPONSE : serep_pkg::TT_NWRITE;
    txq_in_prio <= p;
    txq_in_is_response <= rsp;
    txq_in_valid <= 1'b1;
    step();
    txq_in_valid <= 1'b0;
    step();
  endtask : enq
  task automatic pop(logic [2:0] exp);
    repeat (40) if (tx_valid !== 1'b1) step();
    chk("tx_head", {tx_valid, tx_is_response, tx_prio}, {1'b1, exp});
    chk("tx_ttype", tx_ttype, exp[2] ? serep_pkg::TT_RESPONSE : serep_pkg::TT_NWRITE);
    stall <= 1'b0;
    step();
    stall <= 1'b1;
    step();
  endtask : pop
  task automatic req();
    link_req_sent <= 1'b1;
    step();
    link_req_sent <= 1'b0;
    repeat (2) step();
  endtask : req
  // ==========
  // Main sequence
  initial begin
    repeat (8) step();
    rstn <= 1'b1;
    step();
    reg_io(4'h0, 1'b0, 16'h03FF);
    reg_io(4'h1, 1'b0, 16'h0003);
    reg_io(4'h2, 1'b0, 16'h0002);
    reg_io(4'h3, 1'b0, 16'h0001);
    reg_io(4'h4, 1'b0, 16'h0000);
    reg_io(4'hE, 1'b0, 16'h0000);
    rx_chk(serep_pkg::TT_NREAD, 1'b0, 10'h3FF, 1'b1, 3'h3);
    rx_chk(serep_pkg::TT_NREAD, 1'b0, 10'h3FE, 1'b1, 3'h1);
    rx_chk(serep_pkg::TT_RESPONSE, 1'b1, 10'h3FF, 1'b1, 3'h2);
    rx_chk(serep_pkg::TT_USER_DEF, 1'b0, 10'h3FF, 1'b1, 3'h4);
    rx_chk(serep_pkg::TT_MESSAGE, 1'b0, 10'h000, 1'b1, 3'h1);
    rx_chk(serep_pkg::TT_PORT_WRITE, 1'b0, 10'h000, 1'b0, 3'h6);
    reg_io(4'h0, 1'b1, 16'h0155);
    rx_chk(serep_pkg::TT_SWRITE, 1'b0, 10'h155, 1'b1, 3'h3);
    rx_chk(serep_pkg::TT_NREAD, 1'b0, 10'h3FF, 1'b1, 3'h1);
    idle_train_done <= 1'b1;
    step();
    idle_train_done <= 1'b0;
    repeat (2) step();
    chk("idle_sel", {idle1_sel, idle2_sel}, 2'b01);
    chk("idle2_info", idle2_info[22:16], {link_width, lane_polarity});
    enq(2'h0, 1'b0);
    enq(2'h2, 1'b0);
    enq(2'h1, 1'b1);
    bufs <= 6'h0A;
    pop(3'b101);
    pop(3'b010);
    pop(3'b000);
    bufs <= 6'h00;
    // Let the lower credit reach the gate before queueing
    repeat (2) step();
    enq(2'h0, 1'b0);
    enq(2'h3, 1'b0);
    chk("tx_valid", tx_valid, 1'b0);
    bufs <= 6'h02;
    pop(3'b011);
    repeat (4) step();
    chk("tx_valid", tx_valid, 1'b0);
    reg_io(4'h5, 1'b0, 16'h080A);
    bufs <= 6'h03;
    pop(3'b000);
    tx_ctrl <= 1'b0;
    bufs <= 6'h00;
    repeat (2) step();
    chk("tx_fc_active", tx_fc_active, 1'b0);
    enq(2'h0, 1'b0);
    pop(3'b000);
    reg_io(4'h4, 1'b1, 16'h0002);
    repeat (3) req();
    answer <= 1'b0;
    repeat (2) req();
    chk("link_fatal", link_fatal, 1'b0);
    req();
    chk("link_fatal", link_fatal, 1'b1);
    rstn <= 1'b0;
    repeat (2) step();
    rstn <= 1'b1;
    step();
    reg_io(4'h4, 1'b1, 16'h0007);
    repeat (8) req();
    chk("link_fatal", link_fatal, 1'b0);
    // Training after the second reset picks the first idle
    idle_train_pick2 <= 1'b0;
    idle_train_done <= 1'b1;
    step();
    idle_train_done <= 1'b0;
    repeat (2) step();
    chk("idle1_short", {idle1_sel, idle2_sel, short_ctrl_sym}, 3'b101);
    end_of_test();
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    end_of_test();
  end
endmodule : serep_core_test
`default_nettype wire
